// ---- src/epic_ctrl.sv ----
// external pin and pin-change interrupt controller with apb register access
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
// Contract
// - pin1 vector enabled only when enable bit 7 and global enable set
// - pin0 vector enabled only when enable bit 6 and global enable set
// - two sense bits choose level, any edge, falling or rising edge
// - pin activity requests interrupt even when pin is driven as output
// - bit 5 enables pin-change for inputs 7..0 and 15..12
// - bit 4 enables pin-change for inputs 11..8
// - each pin-change input contributes only if its mask bit is set
// - both pin-change groups share one vector
// - enable register bits 3..0 always read zero
// - pin1 activity sets flag bit 7
// - pin0 activity sets flag bit 6
// - set pin flag plus its enable plus global enable requests that vector; the pin-change flag needs only global enable
// - flag clears when its vector is taken
// - writing one clears a flag, zero leaves it
// - pin1 and pin0 flags held zero while level sensing is selected
module epic_ctrl
  import epic_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins, seen regardless of their direction
  input wire logic ext_pin1,
  input wire logic ext_pin0,
  input wire logic [7:0] pinchg_inputs_low,
  input wire logic [3:0] pinchg_inputs_mid,
  input wire logic [3:0] pinchg_inputs_top,
  // cpu side
  input wire logic global_irq_enable,
  input wire logic [2:0] vector_taken,
  output epic_vec_s vector_request
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 18;
  logic [NPIN-1:0] pins_raw;
  logic [NPIN-1:0] sync1_q, sync2_q, sync3_q;
  logic [NPIN-1:0] stable_q; // accepted level, updates when stages 2 and 3 agree
  logic [NPIN-1:0] changed;
  assign pins_raw = {ext_pin1, ext_pin0, pinchg_inputs_top, pinchg_inputs_mid,
                     pinchg_inputs_low};

  // the third stage costs a cycle of latency but rejects a one-cycle glitch
  // three stages per pin; no logic reads stage one except stage two
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_ff @(posedge mclk) begin
        if (reset) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
          sync3_q[g] <= 1'b0;
          stable_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= pins_raw[g];
          sync2_q[g] <= sync1_q[g];
          sync3_q[g] <= sync2_q[g];
          if (sync2_q[g] == sync3_q[g]) begin
            stable_q[g] <= sync3_q[g];
          end
        end
      end
      assign changed[g] = (sync2_q[g] == sync3_q[g]) && (sync3_q[g] != stable_q[g]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] enables_q;
  logic [1:0] sense_q;
  logic [7:0] mask_low_q, mask_high_q;
  logic pin1_flag_q, pin0_flag_q, pinchg_flag_q;
  logic wr_en;
  epic_sense_e sense;
  assign sense = epic_sense_e'(sense_q);
  assign wr_en = psel && penable && pwrite;
  // reads need no strobe: data is latched in the setup cycle below
  assign pready = 1'b1; // zero wait states
  assign pslverr = 1'b0;

  // software-written configuration; the reserved enable bits never store
  always_ff @(posedge mclk) begin
    if (reset) begin
      enables_q <= RST_BYTE;
      sense_q <= 2'b00;
      mask_low_q <= RST_BYTE;
      mask_high_q <= RST_BYTE;
    end else if (wr_en) begin
      unique case (paddr)
        ADDR_ENABLES: enables_q <= pwdata[7:0] & ENABLES_WMASK;
        ADDR_CONTROL: sense_q <= pwdata[1:0];
        ADDR_MASK_LOW: mask_low_q <= pwdata[7:0];
        ADDR_MASK_HIGH: mask_high_q <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // trigger detection
  // ----------------------------------------------------------------
  logic pin1_hit, pin0_hit, pc_hit;
  logic [15:0] pc_mask;
  logic [15:0] pc_gate;
  assign pc_mask = {mask_high_q, mask_low_q};
  // group a (bit 5) covers 7..0 and 15..12, group b (bit 4) covers 11..8
  assign pc_gate = {{4{enables_q[BIT_PCA]}}, {4{enables_q[BIT_PCB]}},
                    {8{enables_q[BIT_PCA]}}};

  // edge choice per sense code; pins are watched even when driven as outputs
  function automatic logic edge_hit(input epic_sense_e s, input logic chg,
                                    input logic newlvl);
    unique case (s)
      SENSE_ANY: edge_hit = chg;
      SENSE_FALL: edge_hit = chg && !newlvl;
      SENSE_RISE: edge_hit = chg && newlvl;
      SENSE_LEVEL: edge_hit = 1'b0;
    endcase
  endfunction

  assign pin1_hit = edge_hit(sense, changed[17], sync3_q[17]);
  assign pin0_hit = edge_hit(sense, changed[16], sync3_q[16]);
  assign pc_hit = |(changed[15:0] & pc_mask & pc_gate);

  // ----------------------------------------------------------------
  // flags: a new event wins over a clear in the same cycle
  // ----------------------------------------------------------------
  logic flag_wr;
  assign flag_wr = wr_en && (paddr == ADDR_FLAGS);
  // level clause first, so a level-sensed pin never leaves a stale edge flag

  always_ff @(posedge mclk) begin
    if (reset) begin
      pin1_flag_q <= 1'b0;
    end else if (sense == SENSE_LEVEL) begin
      pin1_flag_q <= 1'b0;
    end else if (pin1_hit) begin
      pin1_flag_q <= 1'b1;
    end else if (vector_taken[2] || (flag_wr && pwdata[BIT_PIN1])) begin
      pin1_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pin0_flag_q <= 1'b0;
    end else if (sense == SENSE_LEVEL) begin
      pin0_flag_q <= 1'b0;
    end else if (pin0_hit) begin
      pin0_flag_q <= 1'b1;
    end else if (vector_taken[1] || (flag_wr && pwdata[BIT_PIN0])) begin
      pin0_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      pinchg_flag_q <= 1'b0;
    end else if (pc_hit) begin
      pinchg_flag_q <= 1'b1;
    end else if (vector_taken[0] || (flag_wr && pwdata[BIT_PCA])) begin
      pinchg_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // vector requests; level mode requests while the pin is low
  // ----------------------------------------------------------------
  // level mode bypasses the flag, so the request drops once the pin is high
  logic pin1_src, pin0_src;
  assign pin1_src = (sense == SENSE_LEVEL) ? !stable_q[17] : pin1_flag_q;
  assign pin0_src = (sense == SENSE_LEVEL) ? !stable_q[16] : pin0_flag_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      vector_request <= '0;
    end else begin
      vector_request.pin1 <= pin1_src && enables_q[BIT_PIN1] && global_irq_enable;
      vector_request.pin0 <= pin0_src && enables_q[BIT_PIN0] && global_irq_enable;
      vector_request.pinchg <= pinchg_flag_q && global_irq_enable;
    end
  end

  // ----------------------------------------------------------------
  // read mux, registered at the setup phase so data stands in access
  // ----------------------------------------------------------------
  // limitation: a flag that sets between setup and access shows on the next read
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        ADDR_ENABLES: prdata <= {24'h000000, enables_q & ENABLES_WMASK};
        ADDR_FLAGS: prdata <= {24'h000000, pin1_flag_q, pin0_flag_q, pinchg_flag_q, 5'h00};
        ADDR_CONTROL: prdata <= {30'h0, sense_q};
        ADDR_MASK_LOW: prdata <= {24'h000000, mask_low_q};
        ADDR_MASK_HIGH: prdata <= {24'h000000, mask_high_q};
        ADDR_VECTOR: prdata <= {29'h0, vector_request};
        default: prdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_level_flag_zero: assert property (@(posedge mclk) disable iff (reset)
    (sense == SENSE_LEVEL) |=> !pin1_flag_q && !pin0_flag_q)
    else $error("flag set during level sensing");
  a_pin1_sets: assert property (@(posedge mclk) disable iff (reset)
    pin1_hit |=> pin1_flag_q)
    else $error("pin1 event did not set flag");
  a_pin0_sets: assert property (@(posedge mclk) disable iff (reset)
    pin0_hit |=> pin0_flag_q)
    else $error("pin0 event did not set flag");
  a_pc_sets: assert property (@(posedge mclk) disable iff (reset)
    pc_hit |=> pinchg_flag_q)
    else $error("pin change did not set flag");
  a_pin1_gate: assert property (@(posedge mclk) disable iff (reset)
    vector_request.pin1 |-> $past(enables_q[BIT_PIN1]) && $past(global_irq_enable))
    else $error("pin1 vector without enable");
  a_pin0_gate: assert property (@(posedge mclk) disable iff (reset)
    vector_request.pin0 |-> $past(enables_q[BIT_PIN0]) && $past(global_irq_enable))
    else $error("pin0 vector without enable");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (reset)
    enables_q[3:0] == 4'h0)
    else $error("reserved enable bits stored");
  a_w1c_clear: assert property (@(posedge mclk) disable iff (reset)
    flag_wr && pwdata[BIT_PCA] && !pc_hit |=> !pinchg_flag_q)
    else $error("write one did not clear flag");
  a_vec_clear: assert property (@(posedge mclk) disable iff (reset)
    vector_taken[2] && !pin1_hit |=> !pin1_flag_q)
    else $error("vector entry did not clear flag");
  a_mask_gate: assert property (@(posedge mclk) disable iff (reset)
    !pinchg_flag_q && !(|(changed[15:0] & pc_mask)) |=> !pinchg_flag_q)
    else $error("unmasked pin raised change flag");

  // ----------------------------------------------------------------
  // request path, built from named steps
  // ----------------------------------------------------------------
  // a pending edge flag that is enabled must reach the cpu one cycle later
  sequence s_pin1_armed;
    (sense != SENSE_LEVEL) && pin1_flag_q && enables_q[BIT_PIN1] && global_irq_enable;
  endsequence
  sequence s_pin0_armed;
    (sense != SENSE_LEVEL) && pin0_flag_q && enables_q[BIT_PIN0] && global_irq_enable;
  endsequence
  sequence s_pc_armed;
    pinchg_flag_q && global_irq_enable;
  endsequence
  // level sensing asks for service for as long as the settled pin is low
  sequence s_pin1_level_low;
    (sense == SENSE_LEVEL) && !stable_q[17] && enables_q[BIT_PIN1] && global_irq_enable;
  endsequence
  a_pin1_request: assert property (@(posedge mclk) disable iff (reset)
    s_pin1_armed |=> vector_request.pin1)
    else $error("enabled pin1 flag not requested");
  a_pin0_request: assert property (@(posedge mclk) disable iff (reset)
    s_pin0_armed |=> vector_request.pin0)
    else $error("enabled pin0 flag not requested");
  a_pc_vector: assert property (@(posedge mclk) disable iff (reset)
    s_pc_armed |=> vector_request.pinchg)
    else $error("pin change flag not requested");
  a_level_request: assert property (@(posedge mclk) disable iff (reset)
    s_pin1_level_low |=> vector_request.pin1)
    else $error("low level on pin1 not requested");

  // ----------------------------------------------------------------
  // edge selection, one sequence per accepted edge kind
  // ----------------------------------------------------------------
  sequence s_pin1_rise;
    (sense == SENSE_RISE) && changed[17] && sync3_q[17];
  endsequence
  sequence s_pin1_fall;
    (sense == SENSE_FALL) && changed[17] && !sync3_q[17];
  endsequence
  sequence s_pin0_any;
    (sense == SENSE_ANY) && changed[16];
  endsequence
  a_rise_sets: assert property (@(posedge mclk) disable iff (reset)
    s_pin1_rise |=> pin1_flag_q)
    else $error("rising edge did not set pin1 flag");
  a_fall_sets: assert property (@(posedge mclk) disable iff (reset)
    s_pin1_fall |=> pin1_flag_q)
    else $error("falling edge did not set pin1 flag");
  a_any_sets: assert property (@(posedge mclk) disable iff (reset)
    s_pin0_any |=> pin0_flag_q)
    else $error("any edge did not set pin0 flag");
endmodule

// ---- src/epic_pkg.sv ----
// package: register map, field positions and types of the external and pin-change interrupt block
package epic_pkg;
  // ----------------------------------------------------------------
  // register byte addresses (apb, one aligned word per register)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ENABLES = 8'h38; // ext_irq_enables
  localparam logic [7:0] IDX_FLAGS = 8'h3a; // ext_irq_flags word index, not word aligned
  localparam logic [7:0] ADDR_FLAGS = {IDX_FLAGS[5:0], 2'b00}; // byte address, four times index
  localparam logic [7:0] ADDR_CONTROL = 8'h3c; // mcu_control_reg sense bits
  localparam logic [7:0] ADDR_MASK_LOW = 8'h40; // pinchg_mask_low
  localparam logic [7:0] ADDR_MASK_HIGH = 8'h44; // pinchg_mask_high
  localparam logic [7:0] ADDR_VECTOR = 8'h48; // vector request status, read only
  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int BIT_PIN1 = 7;
  localparam int BIT_PIN0 = 6;
  localparam int BIT_PCA = 5;
  localparam int BIT_PCB = 4;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ENABLES_WMASK = 8'hf0; // bits 3..0 read zero
  localparam logic [7:0] FLAGS_WMASK = 8'he0;
  localparam int SYNC_STAGES = 3;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SENSE_LEVEL = 2'b00,
    SENSE_ANY = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } epic_sense_e;
  // registered vector request outputs to the cpu, held while the source stays pending
  typedef struct packed {
    logic pin1;
    logic pin0;
    logic pinchg;
  } epic_vec_s;
endpackage

// ---- bench/epic_pin_model.sv ----
// outside-world stand-in that drives the interrupt and pin-change pins
`timescale 1ns/1ps
module epic_pin_model (
  // clock
  input wire logic mclk,
  // pins toward the block
  output logic ext_pin1,
  output logic ext_pin0,
  output logic [7:0] pinchg_inputs_low,
  output logic [3:0] pinchg_inputs_mid,
  output logic [3:0] pinchg_inputs_top
);
  // pins rest low until the bench moves them
  initial begin
    {ext_pin1, ext_pin0, pinchg_inputs_top, pinchg_inputs_mid, pinchg_inputs_low} = 18'h0;
  end
  // held six cycles: shorter pulses could slip past the synchroniser
  task automatic drive(input logic [17:0] lvl);
    @(posedge mclk);
    {ext_pin1, ext_pin0, pinchg_inputs_top, pinchg_inputs_mid, pinchg_inputs_low} <= lvl;
    repeat (6) @(posedge mclk);
  endtask
endmodule

// ---- bench/epic_ctrl_tb.sv ----
// self-checking bench for the external and pin-change interrupt controller
`timescale 1ns/1ps
module epic_ctrl_tb;
  import epic_pkg::*;
  logic mclk, reset, psel, penable, pwrite, global_irq_enable, pready, pslverr, hit, gie;
  logic ext_pin1, ext_pin0;
  logic [7:0] paddr, mlow, mhigh, en, pinchg_inputs_low;
  logic [31:0] pwdata, prdata, rd, r;
  logic [31:0] seed = 32'h1676;
  logic [3:0] pinchg_inputs_mid, pinchg_inputs_top;
  logic [2:0] vector_taken;
  logic [17:0] pins, nxt, chg;
  epic_vec_s vector_request;
  int err_total = 0;
  int checks_done = 0;

  epic_ctrl i_dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_pin1(ext_pin1), .ext_pin0(ext_pin0),
    .pinchg_inputs_low(pinchg_inputs_low), .pinchg_inputs_mid(pinchg_inputs_mid),
    .pinchg_inputs_top(pinchg_inputs_top), .global_irq_enable(global_irq_enable),
    .vector_taken(vector_taken), .vector_request(vector_request));
  epic_pin_model i_pins (.mclk(mclk), .ext_pin1(ext_pin1), .ext_pin0(ext_pin0),
    .pinchg_inputs_low(pinchg_inputs_low), .pinchg_inputs_mid(pinchg_inputs_mid),
    .pinchg_inputs_top(pinchg_inputs_top));

  // 10 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // setup then access; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic reg_is(input string what, input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check(what, rd, {24'h0, e});
  endtask

  // one-cycle vector entry pulse, then let the request register follow
  task automatic take(input logic [2:0] v);
    @(posedge mclk);
    vector_taken <= v;
    @(posedge mclk);
    vector_taken <= 3'b000;
    repeat (2) @(posedge mclk);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // watchdog: the run needs about 480 cycles
  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    summarize();
  end

  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, global_irq_enable} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    vector_taken = 3'b000;
    pins = 18'h0;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    reg_is("enables", ADDR_ENABLES, RST_BYTE);
    apb(1'b1, ADDR_CONTROL, 8'h03);
    apb(1'b1, ADDR_ENABLES, 8'hff);
    reg_is("enables", ADDR_ENABLES, 8'hf0);
    global_irq_enable <= 1'b1;
    i_pins.drive(18'h20000);
    reg_is("flags", ADDR_FLAGS, 8'h80);
    check("req", {29'h0, vector_request}, 32'h4);
    i_pins.drive(18'h30000);
    apb(1'b1, ADDR_FLAGS, 8'h00);
    reg_is("flags", ADDR_FLAGS, 8'hc0);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge mclk);
    check("req", {29'h0, vector_request}, 32'h0);
    global_irq_enable <= 1'b1;
    apb(1'b1, ADDR_ENABLES, 8'h40);
    repeat (2) @(posedge mclk);
    check("req", {29'h0, vector_request}, 32'h2);
    reg_is("vecstat", ADDR_VECTOR, 8'h02);
    apb(1'b1, ADDR_FLAGS, 8'h80);
    reg_is("flags", ADDR_FLAGS, 8'h40);
    take(3'b010);
    reg_is("flags", ADDR_FLAGS, 8'h00);
    // falling, then any-edge sensing
    apb(1'b1, ADDR_CONTROL, 8'h02);
    i_pins.drive(18'h10000);
    reg_is("flags", ADDR_FLAGS, 8'h80);
    apb(1'b1, ADDR_FLAGS, 8'h80);
    apb(1'b1, ADDR_CONTROL, 8'h01);
    i_pins.drive(18'h30000);
    reg_is("flags", ADDR_FLAGS, 8'h80);
    take(3'b100);
    reg_is("flags", ADDR_FLAGS, 8'h00);
    // level sensing requests while low and never sets a flag
    apb(1'b1, ADDR_ENABLES, 8'hf0);
    i_pins.drive(18'h00000);
    apb(1'b1, ADDR_CONTROL, 8'h00);
    repeat (2) @(posedge mclk);
    check("req", {29'h0, vector_request}, 32'h6);
    reg_is("flags", ADDR_FLAGS, 8'h00);
    i_pins.drive(18'h30000);
    pins = 18'h30000;
    reg_is("flags", ADDR_FLAGS, 8'h00);
    // random masks, group enables and pin changes against the model
    for (int i = 0; i < 12; i++) begin
      r = xs();
      mlow = r[7:0];
      mhigh = r[15:8];
      en = r[23:16] & 8'h30;
      apb(1'b1, ADDR_MASK_LOW, mlow);
      apb(1'b1, ADDR_MASK_HIGH, mhigh);
      apb(1'b1, ADDR_ENABLES, en);
      apb(1'b1, ADDR_FLAGS, 8'h20);
      gie = r[24];
      global_irq_enable <= gie;
      r = xs();
      nxt = {2'b11, r[15:0]};
      chg = nxt ^ pins;
      hit = (|(chg[7:0] & mlow & {8{en[5]}})) | (|(chg[15:12] & mhigh[7:4] & {4{en[5]}}))
        | (|(chg[11:8] & mhigh[3:0] & {4{en[4]}}));
      i_pins.drive(nxt);
      pins = nxt;
      reg_is("flags", ADDR_FLAGS, {2'b00, hit, 5'h00});
      check("req", {29'h0, vector_request}, {31'h0, hit & gie});
      take({r[17:16], 1'b1});
      reg_is("flags", ADDR_FLAGS, 8'h00);
    end
    apb(1'b1, 8'h4c, 8'hff);
    reg_is("unmapped", 8'h4c, 8'h00);
    check("slverr", {31'h0, pslverr}, 32'h0);
    summarize();
  end
endmodule
